// File: test/test_rspr_top.sv
`timescale 1ns/1ps
module test_rspr_top;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, sys_off = 1'b0, pready, pslverr, off_m, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, ctrl_m, rd, r;
    logic [15:0] sec_power, sec_keep;
    int          n_mismatch = 0, total_checks = 0, cycles = 0, seed = 32'hD54D;
    rspr_top i_rspr_top (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SYS_OFF(sys_off),
        .SEC_POWER(sec_power), .SEC_KEEP(sec_keep));
    // 20 MHz clock
    always #25 clk = ~clk;
    // Hang guard, far above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            end_sim;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits on PREADY, extra edge keeps drivers apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);  // Only the hang guard ends a wait
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Section outputs against the model, sampled mid-cycle
    task automatic outs;
        logic [15:0] p;
        @(negedge clk);
        p = off_m ? 16'h0000 : ctrl_m[15:0];
        chk({16'h0000, sec_power}, {16'h0000, p});
        chk({16'h0000, sec_keep}, {16'h0000, p | ctrl_m[31:16]});
        @(posedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        ctrl_m = rspr_pkg::CTRL_RESET;
        off_m = 1'b0;
        @(posedge clk);
        apb(1'b0, rspr_pkg::CTRL_OFS, 32'h0);
        chk(rd, rspr_pkg::CTRL_RESET);
        outs;
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            apb(1'b1, rspr_pkg::CTRL_OFS, r);
            ctrl_m = r;
            outs;
            r = $random(seed);
            apb(1'b1, rspr_pkg::SET_OFS, r);
            ctrl_m = ctrl_m | r;
            apb(1'b0, rspr_pkg::CTRL_OFS, 32'h0);
            chk(rd, ctrl_m);
            outs;
            r = $random(seed);
            apb(1'b1, rspr_pkg::CLR_OFS, r);
            ctrl_m = ctrl_m & ~r;
            apb(1'b0, rspr_pkg::CTRL_OFS, 32'h0);
            chk(rd, ctrl_m);
            outs;
        end
        $display("set and clear test done");
        apb(1'b1, 12'h9F0, 32'hFFFFFFFF);
        chk({31'h00000000, err}, 32'h00000001);
        apb(1'b0, 12'h9F0, 32'h0);
        chk(rd, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001);
        apb(1'b0, rspr_pkg::SET_OFS, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, rspr_pkg::CTRL_OFS, 32'h0);
        chk(rd, ctrl_m);
        chk({31'h00000000, err}, 32'h00000000);
        $display("unmapped test done");
        sys_off <= 1'b1;
        @(posedge clk);
        sys_off <= 1'b0;
        off_m = 1'b1;
        repeat (2) @(posedge clk);
        outs;
        apb(1'b1, rspr_pkg::SET_OFS, 32'h0000FFFF);
        ctrl_m = ctrl_m | 32'h0000FFFF;
        outs;
        apb(1'b0, rspr_pkg::MODE_OFS, 32'h0);
        chk(rd, 32'h00000001);
        apb(1'b0, rspr_pkg::STAT_OFS, 32'h0);
        chk(rd, {ctrl_m[31:16], 16'h0000});
        $display("system off test done");
        apb(1'b1, rspr_pkg::MODE_OFS, 32'h00000000);
        off_m = 1'b0;
        outs;
        apb(1'b0, rspr_pkg::STAT_OFS, 32'h0);
        chk(rd, {ctrl_m[15:0] | ctrl_m[31:16], ctrl_m[15:0]});
        apb(1'b1, rspr_pkg::MODE_OFS, 32'h00000001);
        off_m = 1'b1;
        outs;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        ctrl_m = rspr_pkg::CTRL_RESET;
        off_m = 1'b0;
        @(posedge clk);
        apb(1'b0, rspr_pkg::CTRL_OFS, 32'h0);
        chk(rd, rspr_pkg::CTRL_RESET);
        outs;
        $display("mode and second reset test done");
        end_sim;
    end
endmodule

// File: verilog/rspr_decode.sv
`timescale 1ns/1ps
module rspr_decode
(
    rspr_if.dec bus     // Control word in, section state out
);
    // Per-section supply and retention, OFF mode overrides power
    genvar n;
    generate
        for (n = 0; n < rspr_pkg::NSEC; n++)
        begin : g_sec
            assign bus.supply[n] = bus.ctrl[n] & ~bus.sys_off;
            // Powered sections always keep data; off ones only if kept
            assign bus.retain[n] = bus.supply[n]
                                 | bus.ctrl[rspr_pkg::KEEP_LSB + n];
        end
    endgenerate
endmodule

// File: verilog/rspr_if.sv
`timescale 1ns/1ps
// Control word and section view passed to the supply decoder
interface rspr_if;
    logic [31:0] ctrl;      // Combined power and retention fields
    logic        sys_off;   // System OFF request
    logic [15:0] supply;    // Section powered
    logic [15:0] retain;    // Section contents kept
    modport ctl (output ctrl, output sys_off, input supply, input retain);
    modport dec (input ctrl, input sys_off, output supply, output retain);
endinterface

// File: verilog/rspr_pkg.sv
package rspr_pkg;
    // Register byte offsets
    localparam logic [11:0] CTRL_OFS    = 12'h980;  // Bank 9 power control
    localparam logic [11:0] SET_OFS     = 12'h984;  // Bank 9 set
    localparam logic [11:0] CLR_OFS     = 12'h988;  // Bank 9 clear
    localparam logic [11:0] MODE_OFS    = 12'h98C;  // System OFF request
    localparam logic [11:0] STAT_OFS    = 12'h990;  // Effective supply state
    // Field layout
    localparam int          NSEC        = 16;       // Sections per bank
    localparam int          KEEP_LSB    = 16;       // Retention fields at 16..31
    localparam logic [31:0] CTRL_RESET  = 32'h0000FFFF;
    localparam logic [31:0] ZERO_WORD   = 32'h00000000;
endpackage

// File: verilog/rspr_top.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
// Function
// - Writing one to a retention bit of the clear register switches that retention off.
// - The power control register sits at 0x980 and resets to 0x0000FFFF.
// - Power bit n at 1 keeps section n on in System ON, at 0 switches it off.
// - A powered section always keeps its contents.
// - An unpowered section keeps its contents only if its retention bit is set.
// - System OFF powers off every section regardless of the power bits.
// - Writing one to a bit of the set register turns that setting on.
module rspr_top
#(
    parameter int SECTIONS = rspr_pkg::NSEC  // Sections per bank, fixed by the word layout
)
(
    input  wire logic        CLK,       // 20 MHz clock
    input  wire logic        RESET,     // Synchronous, active high
    input  wire logic        PSEL,      // APB select
    input  wire logic        PENABLE,   // APB access phase
    input  wire logic        PWRITE,    // APB direction
    input  wire logic [11:0] PADDR,     // APB byte address
    input  wire logic [31:0] PWDATA,    // APB write data
    output logic      [31:0] PRDATA,    // APB read data, registered
    output logic             PREADY,    // APB ready, registered
    output logic             PSLVERR,   // Unmapped access
    input  wire logic        SYS_OFF,   // System OFF entry, same clock domain
    output logic      [15:0] SEC_POWER, // Section supplied
    output logic      [15:0] SEC_KEEP   // Section contents retained
);
    // Carrier between the register file and the supply decoder
    rspr_if sec ();

    logic [31:0] ctrl_q, ctrl_d;
    logic        off_q, off_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;
    logic        err_q, err_d;
    logic [15:0] pwr_q, pwr_d;
    logic [15:0] keep_q, keep_d;

    // Power and retention share one word, so only a full bank of sections fits
    if (SECTIONS != rspr_pkg::NSEC)
    begin : g_bad_sections
        $error("SECTIONS must match the register word layout");
    end

    // Address decode used by both read and write paths
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == rspr_pkg::CTRL_OFS) || (a == rspr_pkg::SET_OFS)
              || (a == rspr_pkg::CLR_OFS) || (a == rspr_pkg::MODE_OFS)
              || (a == rspr_pkg::STAT_OFS);
    endfunction

    // Access phase taken once; the answer follows on the next edge
    wire access = PSEL & PENABLE & ~ready_q;   // One wait state, then ready
    wire wr     = access & PWRITE & mapped(PADDR);

    assign sec.ctrl    = ctrl_q;
    assign sec.sys_off = off_q;

    rspr_decode u_dec
    (
        .bus (sec)
    );

    // Control word and System OFF latch
    always_comb
    begin
        ctrl_d = ctrl_q;
        off_d  = off_q | SYS_OFF;  // OFF latches until software clears
        if (wr)
        begin
            unique case (PADDR)
                rspr_pkg::CTRL_OFS: ctrl_d = PWDATA;
                rspr_pkg::SET_OFS:  ctrl_d = ctrl_q | PWDATA;
                rspr_pkg::CLR_OFS:  ctrl_d = ctrl_q & ~PWDATA;
                rspr_pkg::MODE_OFS: off_d  = PWDATA[0] | SYS_OFF;  // Pin wins over a clear
                default:            ctrl_d = ctrl_q;
            endcase
        end
    end

    // Bus answer; registering costs a wait state but keeps reads off the decode path
    always_comb
    begin
        rdata_d = rdata_q;
        ready_d = access;
        err_d   = access & ~mapped(PADDR);
        if (access & ~PWRITE)
        begin
            unique case (PADDR)
                rspr_pkg::CTRL_OFS: rdata_d = ctrl_q;
                rspr_pkg::MODE_OFS: rdata_d = {31'h00000000, off_q};
                rspr_pkg::STAT_OFS: rdata_d = {sec.retain, sec.supply};
                default:            rdata_d = rspr_pkg::ZERO_WORD;
            endcase
        end
    end

    // Section view; leaves through flops so the pins change once per write
    always_comb
    begin
        pwr_d  = sec.supply;
        keep_d = sec.retain;
    end

    // Control registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl_q <= rspr_pkg::CTRL_RESET;
            off_q  <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            off_q  <= off_d;
        end
    end

    // Bus answer registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rdata_q <= rspr_pkg::ZERO_WORD;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    // Section view registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            pwr_q  <= 16'h0000;
            keep_q <= 16'h0000;
        end
        else
        begin
            pwr_q  <= pwr_d;
            keep_q <= keep_d;
        end
    end

    assign PRDATA    = rdata_q;
    assign PREADY    = ready_q;
    assign PSLVERR   = err_q;
    assign SEC_POWER = pwr_q;
    assign SEC_KEEP  = keep_q;

    // Checks
    // Bus phases as this slave sees them
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence

    sequence s_ctrl_read;
        s_access ##0 (!PWRITE && PADDR == rspr_pkg::CTRL_OFS);
    endsequence

    // Reset value and register writes
    AST_RESET_VAL: assert property (
        @(posedge CLK) $fell(RESET) |-> ctrl_q == rspr_pkg::CTRL_RESET)
        else $error("bad reset value");
    AST_CLR: assert property (
        @(posedge CLK) disable iff (RESET)
        wr && PADDR == rspr_pkg::CLR_OFS |=> (ctrl_q & $past(PWDATA)) == rspr_pkg::ZERO_WORD)
        else $error("clear failed");
    AST_SET: assert property (
        @(posedge CLK) disable iff (RESET)
        wr && PADDR == rspr_pkg::SET_OFS |=> (ctrl_q & $past(PWDATA)) == $past(PWDATA))
        else $error("set failed");
    AST_KEEP_ZERO: assert property (
        @(posedge CLK) disable iff (RESET)
        wr && PADDR == rspr_pkg::SET_OFS
        |=> (ctrl_q & ~$past(PWDATA)) == ($past(ctrl_q) & ~$past(PWDATA)))
        else $error("zero bit changed by set");
    AST_CLR_ZERO: assert property (
        @(posedge CLK) disable iff (RESET)
        wr && PADDR == rspr_pkg::CLR_OFS
        |=> (ctrl_q | $past(PWDATA)) == ($past(ctrl_q) | $past(PWDATA)))
        else $error("zero bit changed by clear");

    // Section outputs against the control word
    AST_POWER: assert property (
        @(posedge CLK) disable iff (RESET)
        !off_q |=> SEC_POWER == $past(ctrl_q[15:0]))
        else $error("power mismatch");
    AST_ON_KEEPS: assert property (
        @(posedge CLK) disable iff (RESET)
        ##1 ((SEC_POWER & ~SEC_KEEP) == 16'h0000))
        else $error("powered section lost data");
    AST_OFF_KEEP: assert property (
        @(posedge CLK) disable iff (RESET)
        off_q |=> SEC_KEEP == $past(ctrl_q[31:16]))
        else $error("retention mismatch");

    // System OFF
    AST_SYSOFF: assert property (
        @(posedge CLK) disable iff (RESET)
        SYS_OFF |-> ##2 SEC_POWER == 16'h0000)
        else $error("System OFF left power");
    AST_OFF_POWER: assert property (
        @(posedge CLK) disable iff (RESET)
        off_q |=> SEC_POWER == 16'h0000)
        else $error("section powered in System OFF");
    AST_OFF_STICKY: assert property (
        @(posedge CLK) disable iff (RESET)
        off_q && !(wr && PADDR == rspr_pkg::MODE_OFS) |=> off_q)
        else $error("System OFF dropped without a clear");

    // Bus timing
    AST_ONE_WAIT: assert property ( // One wait state
        @(posedge CLK) disable iff (RESET)
        s_setup ##1 s_access |=> PREADY)
        else $error("ready not after one wait state");
    AST_READY_PULSE: assert property ( // Ready stands one cycle
        @(posedge CLK) disable iff (RESET)
        PREADY |=> !PREADY)
        else $error("ready held too long");
    AST_ERR_WITH_READY: assert property ( // Error only with ready
        @(posedge CLK) disable iff (RESET)
        PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_CTRL_READ: assert property (
        @(posedge CLK) disable iff (RESET)
        s_ctrl_read |=> PRDATA == $past(ctrl_q))
        else $error("control read mismatch");
endmodule
